// [logic/aie_pkg.sv]
// Package of constants for the add instruction execution block
package aie_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] AIE_OFF_INSTR = 8'h00; // Instruction word, write starts execution
  localparam logic [7:0] AIE_OFF_ACC = 8'h04; // Working register
  localparam logic [7:0] AIE_OFF_STATUS = 8'h08; // Flags and busy
  localparam logic [7:0] AIE_OFF_BANK = 8'h0c; // Bank select register
  localparam logic [7:0] AIE_OFF_CTRL = 8'h10; // Extended set enable
  localparam logic [7:0] AIE_OFF_MEM = 8'h14; // Memory address pointer
  localparam logic [7:0] AIE_OFF_MDATA = 8'h18; // Memory data at pointer
  // Opcode patterns
  localparam logic [7:0] AIE_OP_LIT = 8'h0f; // Literal add upper byte
  localparam logic [5:0] AIE_OP_FILE = 6'h09; // 0010 01
  localparam logic [5:0] AIE_OP_FILEC = 6'h08; // 0010 00
  // Field positions
  localparam int AIE_D_BIT = 9;
  localparam int AIE_A_BIT = 8;
  // Status bit positions
  localparam int AIE_ST_C = 0;
  localparam int AIE_ST_DC = 1;
  localparam int AIE_ST_Z = 2;
  localparam int AIE_ST_OV = 3;
  localparam int AIE_ST_N = 4;
  localparam int AIE_ST_BUSY = 5;
  localparam int AIE_ST_ILL = 6;
  // Addressing constants
  localparam logic [7:0] AIE_ACCESS_SPLIT = 8'h60; // Access bank low/high split
  localparam logic [7:0] AIE_ILO_MAX = 8'h5f; // Indexed offset limit, 95
  localparam logic [3:0] AIE_ACCESS_HIGH_BANK = 4'hf; // Upper access bank
  // Reset values
  localparam logic [7:0] AIE_ACC_RST = 8'h00;
  localparam logic [4:0] AIE_FLAGS_RST = 5'h00;
  localparam logic [3:0] AIE_BANK_RST = 4'h0;
  localparam logic [7:0] AIE_INDEX_RST = 8'h00; // Index register base for offset mode
  // Q phases of one instruction cycle
  typedef enum logic [2:0] {AIE_IDLE, AIE_Q1, AIE_Q2, AIE_Q3, AIE_Q4} aie_phase_type;
endpackage

// [logic/aie_add_exec.sv]
// Add instruction execution unit with AXI4-Lite register access
`timescale 1ns/1ps
// How it works
// - Literal opcode adds low byte into accumulator
// - File add sums accumulator and memory byte
// - d clear writes accumulator, memory untouched
// - d set writes result to memory
// - a clear addresses the access bank
// - a set uses bank select register
// - Extended set, a clear, f<=95: indexed offset
// - Carry add sums accumulator, carry, memory
// - Carry add destination follows d bit
// - Four phases: decode, read, compute, write
module aie_add_exec import aie_pkg::*; (
  input wire logic aclk, // Core clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic instr_done // Pulse when an instruction retires
);

  // Resolve a file address into a 12-bit data address
  function automatic logic [11:0] aie_resolve(input logic [7:0] f, input logic a,
      input logic [3:0] bank, input logic ext, input logic [7:0] idx);
    logic [11:0] r;
    r = {bank, f}; // Banked access
    if (!a) begin
      if (ext && (f <= AIE_ILO_MAX)) begin
        r = {4'h0, 8'(idx + f)}; // Indexed offset mode
      end else if (f < AIE_ACCESS_SPLIT) begin
        r = {4'h0, f}; // Lower access bank
      end else begin
        r = {AIE_ACCESS_HIGH_BANK, f}; // Upper access bank
      end
    end
    return r;
  endfunction

  // Data memory, 256 bytes, indexed by low address bits
  logic [7:0] mem_reg [0:255];
  logic [7:0] mem_next [0:255];
  logic [7:0] acc_reg, acc_next; // Working register
  logic [4:0] flags_reg, flags_next; // N OV Z DC C
  logic [3:0] bank_reg, bank_next; // Bank select register
  logic ext_reg, ext_next; // Extended instruction set enable
  logic [7:0] index_reg, index_next; // Index base for offset mode
  logic [7:0] ptr_reg, ptr_next; // Software memory pointer
  logic ill_reg, ill_next; // Last instruction not an add
  logic [15:0] ir_reg, ir_next; // Instruction register
  aie_phase_type ph_reg, ph_next; // Phase counter
  logic [11:0] ea_reg, ea_next; // Effective address
  logic [7:0] opb_reg, opb_next; // Second operand
  logic [8:0] sum_reg, sum_next; // Result with carry
  logic [4:0] nf_reg, nf_next; // Computed flags
  logic kind_lit_reg, kind_lit_next; // Literal form
  logic kind_c_reg, kind_c_next; // Carry form
  logic done_reg, done_next; // Retire pulse
  // Bus channel state
  logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic arr_reg, arr_next, rv_reg, rv_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  // Combinational scratch
  logic [8:0] lo_sum;
  logic [4:0] h_sum;
  logic cin;
  logic do_write;

  // Next-state logic for bus, registers and the execution sequence
  always_comb begin
    mem_next = mem_reg;
    acc_next = acc_reg;
    flags_next = flags_reg;
    bank_next = bank_reg;
    ext_next = ext_reg;
    index_next = index_reg;
    ptr_next = ptr_reg;
    ill_next = ill_reg;
    ir_next = ir_reg;
    ph_next = ph_reg;
    ea_next = ea_reg;
    opb_next = opb_reg;
    sum_next = sum_reg;
    nf_next = nf_reg;
    kind_lit_next = kind_lit_reg;
    kind_c_next = kind_c_reg;
    done_next = 1'b0;
    awr_next = 1'b0;
    wr_next = 1'b0;
    bv_next = bv_reg;
    arr_next = 1'b0;
    rv_next = rv_reg;
    rdata_next = rdata_reg;
    bresp_next = bresp_reg;
    rresp_next = rresp_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    lo_sum = 9'h000;
    h_sum = 5'h00;
    cin = 1'b0;
    do_write = 1'b0;
    // Capture write address and data in either order
    if (s_axi_awvalid && awr_reg) begin
      aw_have_next = 1'b1;
      awa_next = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && wr_reg) begin
      w_have_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    awr_next = !aw_have_next && !awr_reg && s_axi_awvalid && !bv_reg;
    wr_next = !w_have_next && !wr_reg && s_axi_wvalid && !bv_reg;
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    // Execution phases
    unique case (ph_reg)
      AIE_IDLE: begin
      end
      AIE_Q1: begin
        // Decode opcode and addressing
        kind_lit_next = (ir_reg[15:8] == AIE_OP_LIT);
        kind_c_next = (ir_reg[15:10] == AIE_OP_FILEC);
        ill_next = !((ir_reg[15:8] == AIE_OP_LIT) || (ir_reg[15:10] == AIE_OP_FILE)
            || (ir_reg[15:10] == AIE_OP_FILEC));
        ea_next = aie_resolve(ir_reg[7:0], ir_reg[AIE_A_BIT], bank_reg, ext_reg,
            index_reg);
        ph_next = ill_next ? AIE_IDLE : AIE_Q2;
        done_next = ill_next;
      end
      AIE_Q2: begin
        // Read literal or file byte
        opb_next = kind_lit_reg ? ir_reg[7:0] : mem_reg[ea_reg[7:0]];
        ph_next = AIE_Q3;
      end
      AIE_Q3: begin
        // Compute sum and flags
        cin = kind_c_reg ? flags_reg[AIE_ST_C] : 1'b0;
        lo_sum = 9'(acc_reg) + 9'(opb_reg) + 9'(cin);
        h_sum = 5'(acc_reg[3:0]) + 5'(opb_reg[3:0]) + 5'(cin);
        sum_next = lo_sum;
        nf_next[AIE_ST_C] = lo_sum[8];
        nf_next[AIE_ST_DC] = h_sum[4];
        nf_next[AIE_ST_Z] = (lo_sum[7:0] == 8'h00);
        nf_next[AIE_ST_OV] = (acc_reg[7] == opb_reg[7]) && (lo_sum[7] != acc_reg[7]);
        nf_next[AIE_ST_N] = lo_sum[7];
        ph_next = AIE_Q4;
      end
      AIE_Q4: begin
        // Write destination and retire
        flags_next = nf_reg;
        if (kind_lit_reg || !ir_reg[AIE_D_BIT]) begin
          acc_next = sum_reg[7:0];
        end else begin
          mem_next[ea_reg[7:0]] = sum_reg[7:0];
        end
        done_next = 1'b1;
        ph_next = AIE_IDLE;
      end
    endcase
    // Register write once both halves have arrived
    if (aw_have_reg && w_have_reg && !bv_reg) begin
      do_write = 1'b1;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bv_next = 1'b1;
      bresp_next = 2'b00;
      unique case (awa_reg & 8'hfc)
        AIE_OFF_INSTR: begin
          if (ph_reg == AIE_IDLE && ws_reg[1:0] == 2'b11) begin
            ir_next = wd_reg[15:0];
            ph_next = AIE_Q1;
          end else begin
            bresp_next = 2'b10;
          end
        end
        AIE_OFF_ACC: if (ws_reg[0]) acc_next = wd_reg[7:0];
        AIE_OFF_STATUS: if (ws_reg[0]) flags_next = wd_reg[4:0];
        AIE_OFF_BANK: if (ws_reg[0]) bank_next = wd_reg[3:0];
        AIE_OFF_CTRL: begin
          if (ws_reg[0]) ext_next = wd_reg[0];
          if (ws_reg[1]) index_next = wd_reg[15:8];
        end
        AIE_OFF_MEM: if (ws_reg[0]) ptr_next = wd_reg[7:0];
        AIE_OFF_MDATA: if (ws_reg[0]) mem_next[ptr_reg] = wd_reg[7:0];
        default: bresp_next = 2'b10;
      endcase
    end
    // Read channel, one cycle answer
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
    arr_next = !arr_reg && !rv_reg && s_axi_arvalid;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rresp_next = 2'b00;
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr[7:0] & 8'hfc)
        // Effective address of the last instruction sits above the opcode
        AIE_OFF_INSTR: rdata_next = {4'h0, ea_reg, ir_reg};
        AIE_OFF_ACC: rdata_next = {24'h000000, acc_reg};
        AIE_OFF_STATUS: rdata_next = {25'h0000000, ill_reg, ph_reg != AIE_IDLE, flags_reg};
        AIE_OFF_BANK: rdata_next = {28'h0000000, bank_reg};
        AIE_OFF_CTRL: rdata_next = {16'h0000, index_reg, 7'h00, ext_reg};
        AIE_OFF_MEM: rdata_next = {24'h000000, ptr_reg};
        AIE_OFF_MDATA: rdata_next = {24'h000000, mem_reg[ptr_reg]};
        default: rresp_next = 2'b10;
      endcase
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 256; i++) begin
        mem_reg[i] <= 8'h00;
      end
      acc_reg <= AIE_ACC_RST;
      flags_reg <= AIE_FLAGS_RST;
      bank_reg <= AIE_BANK_RST;
      ext_reg <= 1'b0;
      index_reg <= AIE_INDEX_RST;
      ptr_reg <= 8'h00;
      ill_reg <= 1'b0;
      ir_reg <= 16'h0000;
      ph_reg <= AIE_IDLE;
      ea_reg <= 12'h000;
      opb_reg <= 8'h00;
      sum_reg <= 9'h000;
      nf_reg <= 5'h00;
      kind_lit_reg <= 1'b0;
      kind_c_reg <= 1'b0;
      done_reg <= 1'b0;
      awr_reg <= 1'b0;
      wr_reg <= 1'b0;
      bv_reg <= 1'b0;
      arr_reg <= 1'b0;
      rv_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      bresp_reg <= 2'b00;
      rresp_reg <= 2'b00;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else begin
      mem_reg <= mem_next;
      acc_reg <= acc_next;
      flags_reg <= flags_next;
      bank_reg <= bank_next;
      ext_reg <= ext_next;
      index_reg <= index_next;
      ptr_reg <= ptr_next;
      ill_reg <= ill_next;
      ir_reg <= ir_next;
      ph_reg <= ph_next;
      ea_reg <= ea_next;
      opb_reg <= opb_next;
      sum_reg <= sum_next;
      nf_reg <= nf_next;
      kind_lit_reg <= kind_lit_next;
      kind_c_reg <= kind_c_next;
      done_reg <= done_next;
      awr_reg <= awr_next;
      wr_reg <= wr_next;
      bv_reg <= bv_next;
      arr_reg <= arr_next;
      rv_reg <= rv_next;
      rdata_reg <= rdata_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign instr_done = done_reg;

endmodule // aie_add_exec

// [sim/aie_add_exec_asserts.sv]
// Bus handshake and retire checks for the add execution unit
`timescale 1ns/1ps
module aie_add_exec_asserts (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic [1:0] s_axi_bresp, // B code
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R code
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic instr_done // Retire pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken at one edge
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_b_follow; s_wr_taken |-> ##[1:3] s_axi_bvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_r_follow; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_r_err; s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0; endproperty
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  property p_ar_cause; s_axi_arready |-> s_axi_arvalid; endproperty
  property p_done_pulse; instr_done |=> !instr_done; endproperty
  a_b_follow: assert property (p_b_follow) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_follow: assert property (p_r_follow) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_r_err: assert property (p_r_err) else $error("error read not zero");
  a_aw_pulse: assert property (p_aw_pulse) else $error("aw ready too long");
  a_ar_cause: assert property (p_ar_cause) else $error("ar ready unasked");
  a_done_pulse: assert property (p_done_pulse) else $error("retire too long");
endmodule // aie_add_exec_asserts
bind aie_add_exec aie_add_exec_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .instr_done(instr_done));

// [sim/test_add_instruction_exec.sv]
// Self-checking bench for the add execution unit
`timescale 1ns/1ps
module test_add_instruction_exec;
  import aie_pkg::*;
  logic aclk = 1'b0; // Clock, 50 ns
  logic aresetn = 1'b0; // Reset, low
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, q; // Bus words
  logic [3:0] wstrb = 4'h0; // Byte strobes
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Requests
  logic awready, wready, bvalid, arready, rvalid, done; // Answers
  logic [1:0] bresp, rresp; // Answer codes
  int error_cnt = 0, n_checks = 0, done_cnt = 0, i; // Tallies
  logic [7:0] la [3] = '{8'h10, 8'h7f, 8'hff}; // Literal cases: acc
  logic [7:0] lk [3] = '{8'h15, 8'h01, 8'h01}; // Literal
  logic [7:0] ls [3] = '{8'h25, 8'h80, 8'h00}; // Sum
  logic [7:0] lf [3] = '{8'h00, 8'h1a, 8'h07}; // Flags N OV Z DC C
  aie_add_exec u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .instr_done(done));
  always #25 aclk = ~aclk;
  // Count retire pulses
  always @(posedge aclk) if (done === 1'b1) done_cnt <= done_cnt + 1;
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Bus write; released lines show the inverse value
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40 && bvalid !== 1'b1; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    if (bvalid !== 1'b1) begin error_cnt++; test_done; end
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    awaddr <= ~{24'h0, a};
    wdata <= ~d;
  endtask
  // Bus read
  task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40 && rvalid !== 1'b1; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (rvalid !== 1'b1) begin error_cnt++; test_done; end
    d = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    araddr <= ~{24'h0, a};
  endtask
  task chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] v;
    rd(a, v, 2'b00);
    check(nm, v, e);
  endtask
  // Start an instruction and wait until busy clears
  task exec(input logic [15:0] op);
    int k;
    logic [31:0] v;
    wr(AIE_OFF_INSTR, {16'h0, op}, 4'hf, 2'b00);
    v = 32'hffff_ffff;
    for (k = 0; k < 20 && v[AIE_ST_BUSY] !== 1'b0; k++) rd(AIE_OFF_STATUS, v, 2'b00);
    if (v[AIE_ST_BUSY] !== 1'b0) begin error_cnt++; test_done; end
  endtask
  task setmem(input logic [7:0] a, input logic [7:0] d);
    wr(AIE_OFF_MEM, {24'h0, a}, 4'hf, 2'b00);
    wr(AIE_OFF_MDATA, {24'h0, d}, 4'hf, 2'b00);
  endtask
  task memchk(input logic [7:0] a, input logic [7:0] e);
    wr(AIE_OFF_MEM, {24'h0, a}, 4'hf, 2'b00);
    chk(AIE_OFF_MDATA, {24'h0, e}, "mem");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk(AIE_OFF_ACC, 32'h0, "acc_rst");
    chk(AIE_OFF_STATUS, 32'h0, "st_rst");
    chk(AIE_OFF_BANK, 32'h0, "bank_rst");
    chk(AIE_OFF_CTRL, 32'h0, "ctrl_rst");
    rd(8'h1c, q, 2'b10);
    check("unmapped", q, 32'h0);
    wr(8'h1c, 32'h5, 4'hf, 2'b10);
    // Literal adds, plain, overflow and wrap to zero
    for (i = 0; i < 3; i++) begin
      wr(AIE_OFF_ACC, {24'h0, la[i]}, 4'hf, 2'b00);
      exec({AIE_OP_LIT, lk[i]});
      chk(AIE_OFF_ACC, {24'h0, ls[i]}, "lit_sum");
      chk(AIE_OFF_STATUS, {24'h0, lf[i]}, "lit_flags");
    end
    // File add into accumulator, access bank
    wr(AIE_OFF_ACC, 32'h17, 4'hf, 2'b00);
    setmem(8'h20, 8'hc2);
    exec(16'h2420);
    chk(AIE_OFF_ACC, 32'hd9, "file_acc");
    chk(AIE_OFF_INSTR, 32'h0020_2420, "ea_access");
    memchk(8'h20, 8'hc2);
    chk(AIE_OFF_STATUS, 32'h10, "file_flags");
    // File add back to memory through the bank register
    wr(AIE_OFF_BANK, 32'h5, 4'hf, 2'b00);
    wr(AIE_OFF_ACC, 32'h03, 4'hf, 2'b00);
    setmem(8'h30, 8'h05);
    exec(16'h2730);
    memchk(8'h30, 8'h08);
    chk(AIE_OFF_INSTR, 32'h0530_2730, "ea_bank");
    chk(AIE_OFF_ACC, 32'h03, "acc_kept");
    // Carry add, first to accumulator, then to memory
    wr(AIE_OFF_STATUS, 32'h01, 4'hf, 2'b00);
    wr(AIE_OFF_ACC, 32'h4d, 4'hf, 2'b00);
    setmem(8'h40, 8'h02);
    exec(16'h2140);
    chk(AIE_OFF_ACC, 32'h50, "adc_acc");
    chk(AIE_OFF_STATUS, 32'h02, "adc_flags");
    exec(16'h2340);
    memchk(8'h40, 8'h52);
    // Indexed offset at the top of its range
    wr(AIE_OFF_CTRL, 32'h1001, 4'hf, 2'b00);
    wr(AIE_OFF_ACC, 32'h01, 4'hf, 2'b00);
    setmem(8'h6f, 8'h01);
    exec(16'h265f);
    memchk(8'h6f, 8'h02);
    chk(AIE_OFF_INSTR, 32'h006f_265f, "ea_index");
    // Above the offset limit the upper access bank is used
    exec(16'h2060);
    chk(AIE_OFF_INSTR, 32'h0f60_2060, "ea_upper");
    // Partial strobe refused, non-add flagged
    wr(AIE_OFF_INSTR, 32'h0f01, 4'h1, 2'b10);
    exec(16'h1234);
    chk(AIE_OFF_STATUS, 32'h40, "illegal");
    chk(AIE_OFF_ACC, 32'h01, "acc_same");
    check("retired", done_cnt, 32'd10);
    // Reset in mid-run clears the accumulator
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(AIE_OFF_ACC, 32'h0, "acc_rst2");
    chk(AIE_OFF_STATUS, 32'h0, "st_rst2");
    chk(AIE_OFF_CTRL, 32'h0, "ctrl_rst2");
    memchk(8'h6f, 8'h00);
    test_done;
  end
endmodule // test_add_instruction_exec
